// File: verilog/twims_consts.vh
`ifndef TWIMS_CONSTS_VH
`define TWIMS_CONSTS_VH
// Bus monitor state codes.
`define TWIMS_BS_UNKNOWN 2'h0
`define TWIMS_BS_IDLE 2'h1
`define TWIMS_BS_OWNER 2'h2
`define TWIMS_BS_BUSY 2'h3
// Fixed part of each SCL phase: high and low phase each get all of it.
`define TWIMS_PHASE_FIXED 9'h005
// Inactive bus timeout settings and their counts in 10 ns clock cycles.
`define TWIMS_TIMEOUT_50US 2'h1
`define TWIMS_TIMEOUT_100US 2'h2
`define TWIMS_TIMEOUT_200US 2'h3
`define TWIMS_TIMEOUT_OFF 2'h0
`define TWIMS_TO_50_CYC 15'h1388
`define TWIMS_TO_100_CYC 15'h2710
`define TWIMS_TO_200_CYC 15'h4e20
`endif

// File: verilog/twims_sync.v
`timescale 1ns/1ns
`default_nettype none
module twims_sync (
	input wire clk_i,
	input wire resetn_i,
	input wire d_i,
	output wire q_o
);
	reg meta_r;
	reg q_r;
	// Two stages; the first is read only by the second. Reset high, the idle bus level.
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= 1'b1;
			q_r <= 1'b1;
		end else begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end
	assign q_o = q_r;
endmodule // twims_sync
`default_nettype wire

// File: verilog/twims_cond_det.v
`timescale 1ns/1ns
`default_nettype none
module twims_cond_det (
	input wire clk_i,
	input wire resetn_i,
	input wire scl_i,
	input wire sda_i,
	output wire start_o,
	output wire stop_o,
	output wire scl_fall_o
);
	reg scl_d_r;
	reg sda_d_r;
	// Delayed copies of the synchronised lines for edge detection.
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_i;
			sda_d_r <= sda_i;
		end
	end
	// An SDA edge while SCL stays high marks a START or a STOP.
	assign start_o = scl_i & scl_d_r & sda_d_r & ~sda_i;
	assign stop_o = scl_i & scl_d_r & ~sda_d_r & sda_i;
	assign scl_fall_o = scl_d_r & ~scl_i;
endmodule // twims_cond_det
`default_nettype wire

// File: verilog/twims_master.v
`timescale 1ns/1ns
`default_nettype none
`include "twims_consts.vh"
module twims_master #(
	parameter DIV_W = 8,
	parameter TO_W = 15
) (
	input wire clk_i,
	input wire resetn_i,
	input wire enable_i,
	input wire [DIV_W-1:0] scl_period_divider_i,
	input wire [1:0] timeout_sel_i,
	input wire line_condition_wr_i,
	input wire [1:0] line_condition_wdata_i,
	input wire cmd_start_i,
	input wire cmd_stop_i,
	input wire cmd_byte_i,
	input wire cmd_read_i,
	input wire [7:0] tx_data_i,
	input wire tx_nack_i,
	input wire clear_flags_i,
	input wire clear_errors_i,
	input wire scl_in_i,
	input wire sda_in_i,
	output wire scl_out_o,
	output wire scl_oe_o,
	output wire sda_out_o,
	output wire sda_oe_o,
	output wire [1:0] line_condition_field_o,
	output wire write_done_o,
	output wire read_done_o,
	output wire rx_ack_o,
	output wire bus_error_o,
	output wire arb_lost_o,
	output wire clock_hold_o,
	output wire [7:0] rx_data_o,
	output wire cmd_ready_o
);
	localparam P_IDLE = 3'h0;
	localparam P_START = 3'h1;
	localparam P_LOW = 3'h2;
	localparam P_HIGH = 3'h3;
	localparam P_HOLD = 3'h4;
	localparam P_STOP = 3'h5;
	localparam P_STOP2 = 3'h6;

	wire scl_s;
	wire sda_s;
	wire start_det;
	wire stop_det;
	wire scl_fall;
	reg [1:0] bs_r;
	reg [1:0] bs_nxt;
	reg [2:0] ph_r;
	reg [DIV_W:0] cnt_r;
	reg [3:0] bit_r;
	reg [8:0] sh_r;
	reg rd_r;
	reg scl_low_r;
	reg sda_low_r;
	reg wif_r;
	reg rif_r;
	reg rxack_r;
	reg berr_r;
	reg arb_r;
	reg [7:0] rxd_r;
	reg own_start_r;
	reg own_stop_r;
	reg en_d_r;
	reg [TO_W-1:0] to_cnt_r;
	reg [TO_W-1:0] to_lim;
	wire timeout;
	wire [DIV_W:0] phase_len;
	wire collision;

	// Synchronise both lines before anything looks at them.
	twims_sync u_sync_scl (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(scl_in_i), .q_o(scl_s));
	twims_sync u_sync_sda (.clk_i(clk_i), .resetn_i(resetn_i), .d_i(sda_in_i), .q_o(sda_s));
	twims_cond_det u_det (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.scl_i(scl_s),
		.sda_i(sda_s),
		.start_o(start_det),
		.stop_o(stop_det),
		.scl_fall_o(scl_fall)
	);

	// Each phase is 5 plus the divider, giving 10 plus twice the divider per period.
	assign phase_len = {1'b0, scl_period_divider_i} + `TWIMS_PHASE_FIXED;

	// Collision: sending a data bit, we release SDA but see it low with SCL high; ack and read bits are not ours.
	assign collision = (ph_r == P_HIGH) && !rd_r && (bit_r != 4'h8) && !sda_low_r && !sda_s && scl_s;

	// Timeout limit per setting; zero disables it.
	always @* begin
		case (timeout_sel_i)
			`TWIMS_TIMEOUT_50US: to_lim = `TWIMS_TO_50_CYC;
			`TWIMS_TIMEOUT_100US: to_lim = `TWIMS_TO_100_CYC;
			`TWIMS_TIMEOUT_200US: to_lim = `TWIMS_TO_200_CYC;
			default: to_lim = {TO_W{1'b0}};
		endcase
	end
	assign timeout = (timeout_sel_i != `TWIMS_TIMEOUT_OFF) && (to_cnt_r == to_lim);

	// Inactivity counter restarts on a START, a STOP, an SCL fall or a timeout, and stays clear while disabled.
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			to_cnt_r <= {TO_W{1'b0}};
		end else if (!enable_i || start_det || stop_det || scl_fall || timeout) begin
			to_cnt_r <= {TO_W{1'b0}};
		end else begin
			to_cnt_r <= to_cnt_r + 1'b1;
		end
	end

	// Bus state machine.
	always @* begin
		bs_nxt = bs_r;
		case (bs_r)
			`TWIMS_BS_UNKNOWN: begin
				if (stop_det || timeout) bs_nxt = `TWIMS_BS_IDLE;
			end
			`TWIMS_BS_IDLE: begin
				if (own_start_r) bs_nxt = `TWIMS_BS_OWNER;
				else if (start_det) bs_nxt = `TWIMS_BS_BUSY;
			end
			`TWIMS_BS_OWNER: begin
				// A repeated START alone keeps ownership; a collision moves us to busy, a STOP or timeout to idle.
				if (collision) bs_nxt = `TWIMS_BS_BUSY;
				else if (stop_det || own_stop_r || timeout) bs_nxt = `TWIMS_BS_IDLE;
			end
			`TWIMS_BS_BUSY: begin
				if (stop_det || timeout) bs_nxt = `TWIMS_BS_IDLE;
			end
			default: bs_nxt = `TWIMS_BS_UNKNOWN;
		endcase
		if (line_condition_wr_i && line_condition_wdata_i == `TWIMS_BS_IDLE) bs_nxt = `TWIMS_BS_IDLE;
	end

	// Disable or reset is the only way back to unknown.
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bs_r <= `TWIMS_BS_UNKNOWN;
			en_d_r <= 1'b0;
		end else begin
			en_d_r <= enable_i;
			if (!enable_i || !en_d_r) bs_r <= `TWIMS_BS_UNKNOWN;
			else bs_r <= bs_nxt;
		end
	end

	// Commands are accepted only when no flag holds the clock and the phase engine rests.
	assign cmd_ready_o = enable_i && !wif_r && !rif_r && (ph_r == P_IDLE || ph_r == P_HOLD);

	// Phase engine: generates SCL, shifts data, checks arbitration.
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ph_r <= P_IDLE;
			cnt_r <= {(DIV_W+1){1'b0}};
			bit_r <= 4'h0;
			sh_r <= 9'h1ff;
			rd_r <= 1'b0;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
			wif_r <= 1'b0;
			rif_r <= 1'b0;
			rxack_r <= 1'b0;
			berr_r <= 1'b0;
			arb_r <= 1'b0;
			rxd_r <= 8'h00;
			own_start_r <= 1'b0;
			own_stop_r <= 1'b0;
		end else begin
			own_start_r <= 1'b0;
			own_stop_r <= 1'b0;
			// Clearing the flags drops clock_hold_o and lets commands in; SCL stays low until a command.
			if (clear_flags_i) begin
				wif_r <= 1'b0;
				rif_r <= 1'b0;
			end
			if (clear_errors_i) begin
				arb_r <= 1'b0;
				berr_r <= 1'b0;
			end
			if (!enable_i) begin
				ph_r <= P_IDLE;
				scl_low_r <= 1'b0;
				sda_low_r <= 1'b0;
			end else begin
				case (ph_r)
					P_IDLE: begin
						// Only an idle bus may be claimed.
						if (cmd_start_i && cmd_ready_o && bs_r == `TWIMS_BS_IDLE) begin
							sda_low_r <= 1'b1;
							cnt_r <= phase_len;
							ph_r <= P_START;
							own_start_r <= 1'b1;
						end
					end
					P_START: begin
						if (cnt_r != 0) cnt_r <= cnt_r - 1'b1;
						else begin
							// SCL already low is observed by us first via our own drive.
							scl_low_r <= 1'b1;
							ph_r <= P_HOLD;
						end
					end
					P_LOW: begin
						// Fall time counts inside the low phase.
						if (cnt_r != 0) cnt_r <= cnt_r - 1'b1;
						else begin
							scl_low_r <= 1'b0;
							// Wait until SCL is actually high, another party may stretch.
							if (scl_s) begin
								cnt_r <= phase_len;
								ph_r <= P_HIGH;
							end
						end
					end
					P_HIGH: begin
						if (collision) begin
							// Drop SDA and SCL and wait for idle.
							arb_r <= 1'b1;
							wif_r <= 1'b1;
							sda_low_r <= 1'b0;
							scl_low_r <= 1'b0;
							ph_r <= P_IDLE;
						end else if (!scl_s) begin
							// Another master finished its high first; join its low.
							scl_low_r <= 1'b1;
							cnt_r <= phase_len;
							ph_r <= P_LOW;
						end else if (cnt_r != 0) begin
							cnt_r <= cnt_r - 1'b1;
						end else begin
							scl_low_r <= 1'b1;
							if (bit_r == 4'h8) begin
								rxack_r <= sda_s;
								if (rd_r) rif_r <= 1'b1;
								else wif_r <= 1'b1;
								ph_r <= P_HOLD;
							end else begin
								if (rd_r) rxd_r <= {rxd_r[6:0], sda_s};
								bit_r <= bit_r + 1'b1;
								cnt_r <= phase_len;
								ph_r <= P_LOW;
							end
						end
					end
					P_HOLD: begin
						// SCL stays low in hold until a byte or STOP command is accepted.
						if (cmd_byte_i && cmd_ready_o) begin
							rd_r <= cmd_read_i;
							sh_r <= cmd_read_i ? {8'hff, tx_nack_i} : {tx_data_i, 1'b1};
							sda_low_r <= cmd_read_i ? 1'b0 : ~tx_data_i[7];
							bit_r <= 4'h0;
							cnt_r <= phase_len;
							ph_r <= P_LOW;
						end else if (cmd_stop_i && cmd_ready_o) begin
							sda_low_r <= 1'b1;
							cnt_r <= phase_len;
							ph_r <= P_STOP;
						end
					end
					P_STOP: begin
						if (cnt_r != 0) cnt_r <= cnt_r - 1'b1;
						else begin
							scl_low_r <= 1'b0;
							if (scl_s) begin
								cnt_r <= phase_len;
								ph_r <= P_STOP2;
							end
						end
					end
					P_STOP2: begin
						if (cnt_r != 0) cnt_r <= cnt_r - 1'b1;
						else begin
							sda_low_r <= 1'b0;
							own_stop_r <= 1'b1;
							ph_r <= P_IDLE;
						end
					end
					default: ph_r <= P_IDLE;
				endcase
				// Present the next bit on SDA at the start of the low phase that follows the high phase of each of data bits 0 to 7.
				if (ph_r == P_HIGH && scl_s && !collision && cnt_r == 0 && bit_r != 4'h8) begin
					sda_low_r <= rd_r ? ((bit_r == 4'h7) ? ~sh_r[0] : 1'b0) : ~sh_r[7 - bit_r[2:0]];
				end
				// An unexpected START or STOP inside our transfer is a bus error.
				if ((start_det || stop_det) && (ph_r == P_LOW || ph_r == P_HIGH)) begin
					berr_r <= 1'b1;
					arb_r <= 1'b1;
					wif_r <= 1'b1;
					sda_low_r <= 1'b0;
					scl_low_r <= 1'b0;
					ph_r <= P_IDLE;
				end
			end
		end
	end

	// Open-drain drive: output tied low, enable pulls the line.
	assign scl_out_o = 1'b0;
	assign scl_oe_o = scl_low_r;
	assign sda_out_o = 1'b0;
	assign sda_oe_o = sda_low_r;
	assign line_condition_field_o = bs_r;
	assign write_done_o = wif_r;
	assign read_done_o = rif_r;
	assign rx_ack_o = rxack_r;
	assign bus_error_o = berr_r;
	assign arb_lost_o = arb_r;
	assign clock_hold_o = (wif_r | rif_r) & scl_low_r;
	assign rx_data_o = rxd_r;
endmodule // twims_master
`default_nettype wire

// File: sim/twims_master_monitor.sv
`timescale 1ns/1ns
`default_nettype none
`include "twims_consts.vh"
module twims_master_monitor #(
	parameter DIV_W = 8
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic enable_i,
	input wire logic [DIV_W-1:0] scl_period_divider_i,
	input wire logic line_condition_wr_i,
	input wire logic [1:0] line_condition_wdata_i,
	input wire logic cmd_start_i,
	input wire logic cmd_ready_o,
	input wire logic scl_in_i,
	input wire logic scl_oe_o,
	input wire logic sda_oe_o,
	input wire logic [1:0] line_condition_field_o,
	input wire logic write_done_o,
	input wire logic read_done_o,
	input wire logic arb_lost_o
);
	logic [9:0] hi_r;
	// Counts released high SCL cycles; it saturates so a long idle bus cannot wrap it.
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hi_r <= 10'h000;
		end else begin
			hi_r <= (!scl_in_i || scl_oe_o) ? 10'h000 : hi_r + {9'h000, hi_r != 10'h3ff};
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	property p_rst; $rose(resetn_i) |-> line_condition_field_o == `TWIMS_BS_UNKNOWN; endproperty
	a_rst: assert property (p_rst) else $error("state not unknown after reset");
	property p_off; !enable_i ##1 !enable_i |-> line_condition_field_o == `TWIMS_BS_UNKNOWN; endproperty
	a_off: assert property (p_off) else $error("state not unknown while disabled");
	property p_keep; enable_i && line_condition_field_o != `TWIMS_BS_UNKNOWN ##1 enable_i
		|-> line_condition_field_o != `TWIMS_BS_UNKNOWN; endproperty
	a_keep: assert property (p_keep) else $error("known state fell back to unknown");
	property p_idle; enable_i && $past(enable_i) && line_condition_wr_i && line_condition_wdata_i == 2'h1
		|=> line_condition_field_o == `TWIMS_BS_IDLE; endproperty
	a_idle: assert property (p_idle) else $error("state write did not give idle");
	property p_own; cmd_start_i && cmd_ready_o && line_condition_field_o == `TWIMS_BS_IDLE
		|=> sda_oe_o ##1 line_condition_field_o == `TWIMS_BS_OWNER; endproperty
	a_own: assert property (p_own) else $error("own start did not give owner");
	property p_lost; arb_lost_o && $past(arb_lost_o) |-> !sda_oe_o && !scl_oe_o; endproperty
	a_lost: assert property (p_lost) else $error("lines driven after lost arbitration");
	property p_hold; ((write_done_o || read_done_o) && !arb_lost_o) [*2] |-> scl_oe_o; endproperty
	a_hold: assert property (p_hold) else $error("clock not held while done flag set");
	property p_high; $rose(scl_oe_o) && $past(scl_in_i) |-> hi_r >= `TWIMS_PHASE_FIXED + scl_period_divider_i;
	endproperty
	a_high: assert property (p_high) else $error("high phase too short");
endmodule // twims_master_monitor
bind twims_master twims_master_monitor #(.DIV_W(DIV_W)) u_monitor (.clk_i, .resetn_i, .enable_i, .scl_period_divider_i,
	.line_condition_wr_i, .line_condition_wdata_i, .cmd_start_i, .cmd_ready_o, .scl_in_i, .scl_oe_o, .sda_oe_o,
	.line_condition_field_o, .write_done_o, .read_done_o, .arb_lost_o);
`default_nettype wire

// File: sim/twims_bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
module twims_bus_partner (
	input wire logic clk_i,
	input wire logic scl_oe_i,
	input wire logic sda_oe_i,
	input wire logic [1:0] mode_i,
	input wire logic [7:0] data_i,
	input wire logic stretch_i,
	input wire logic ext_sda_i,
	output wire logic scl_o,
	output wire logic sda_o
);
	logic [3:0] bit_r = 4'h9;
	logic [5:0] hold_r = 6'h00;
	logic scl_d_r = 1'b1;
	logic sda_d_r = 1'b1;
	logic pull_sda;
	// Mode 0 acks, 1 stays off, 2 sends data MSB first, 3 contends on data bits only, never on start or stop.
	assign pull_sda = (mode_i == 2'h0 && bit_r == 4'h8) || (mode_i == 2'h3 && bit_r < 4'h8)
		|| (mode_i == 2'h2 && bit_r < 4'h8 && !data_i[3'h7 - bit_r[2:0]]);
	// Released lines float high through the pull-ups.
	assign scl_o = !(scl_oe_i || hold_r != 6'h00);
	assign sda_o = !(sda_oe_i || ext_sda_i || pull_sda);
	// A stretch begins only on a fall already made, so it lengthens low and never shortens high.
	always @(posedge clk_i) begin
		scl_d_r <= scl_o;
		sda_d_r <= sda_o;
		if (scl_o && sda_d_r && !sda_o) begin
			bit_r <= 4'hf;
		end else if (scl_d_r && !scl_o && bit_r != 4'h9) begin
			bit_r <= bit_r + 4'h1;
		end
		if (scl_d_r && !scl_o && stretch_i) begin
			hold_r <= 6'h28;
		end else if (hold_r != 6'h00) begin
			hold_r <= hold_r - 6'h01;
		end
	end
endmodule // twims_bus_partner
`default_nettype wire

// File: sim/twi_master_bus_state_clocking_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "twims_consts.vh"
module twi_master_bus_state_clocking_test;
	logic clk_i = 0, resetn_i = 0, enable_i = 0, line_condition_wr_i = 0, cmd_start_i = 0, cmd_stop_i = 0;
	logic cmd_byte_i = 0, cmd_read_i = 0, clear_flags_i = 0, clear_errors_i = 0, stretch = 0, ext_sda = 0, look = 0;
	logic [1:0] timeout_sel_i = 0, mode = 0, sel = 0, wdata = 2'h3;
	logic [7:0] tx_data_i = 0, peer_data = 0, div = 8'h04;
	logic [31:0] seed = 32'h7beb_bd45;
	wire logic scl_in_i, sda_in_i, scl_oe_o, sda_oe_o, write_done_o, read_done_o, rx_ack_o, bus_error_o, arb_lost_o;
	wire logic clock_hold_o, cmd_ready_o;
	wire logic [1:0] line_condition_field_o;
	wire logic [7:0] rx_data_o;
	int mismatches = 0, tests_run = 0, m;
	logic [7:0] notes[$];
	// Dividers up to 15 keep each SCL period short and well inside the mode limits.
	twims_master DUT (.clk_i, .resetn_i, .enable_i, .scl_period_divider_i(div), .timeout_sel_i,
		.line_condition_wr_i, .line_condition_wdata_i(wdata), .cmd_start_i, .cmd_stop_i, .cmd_byte_i, .cmd_read_i,
		.tx_data_i, .tx_nack_i(1'b1), .clear_flags_i, .clear_errors_i, .scl_in_i, .sda_in_i, .scl_out_o(), .scl_oe_o,
		.sda_out_o(), .sda_oe_o, .line_condition_field_o, .write_done_o, .read_done_o, .rx_ack_o, .bus_error_o,
		.arb_lost_o, .clock_hold_o, .rx_data_o, .cmd_ready_o);
	twims_bus_partner peer (.clk_i, .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .mode_i(mode), .data_i(peer_data),
		.stretch_i(stretch), .ext_sda_i(ext_sda), .scl_o(scl_in_i), .sda_o(sda_in_i));
	// Free-running 100 MHz clock.
	initial forever #5 clk_i = ~clk_i;
	function logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task note(input logic [1:0] s, input logic [7:0] v);
		@(posedge clk_i);
		sel <= s;
		look <= 1;
		notes.push_back(v);
		@(posedge clk_i);
		look <= 0;
	endtask
	task cmp_state(input logic [7:0] e);
		tests_run++;
		if (line_condition_field_o !== e[1:0]) begin
			mismatches++;
			$display("wrong value line_condition_field expected %h seen %h", e[1:0], line_condition_field_o);
		end
	endtask
	task cmp_bits(input logic [7:0] e);
		logic [7:0] s;
		s = sel == 2'h1 ? rx_data_o : sel == 2'h2 ? {2'h0, clock_hold_o, arb_lost_o, bus_error_o, rx_ack_o,
			read_done_o, write_done_o} : {5'h00, arb_lost_o, read_done_o, write_done_o};
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", sel == 2'h1 ? "rx_data" : "flags", e, s);
		end
	endtask
	// Notes are judged half a cycle after being posted, once registered outputs have settled.
	always @(negedge clk_i) begin
		if (look) begin
			if (sel == 2'h0) cmp_state(notes.pop_front());
			else cmp_bits(notes.pop_front());
		end
	end
	task pulse(input logic [4:0] c);
		@(posedge clk_i);
		{cmd_start_i, cmd_stop_i, cmd_byte_i, clear_flags_i, clear_errors_i} <= c;
		@(posedge clk_i);
		{cmd_start_i, cmd_stop_i, cmd_byte_i, clear_flags_i, clear_errors_i} <= 5'h00;
	endtask
	task cmd(input logic [4:0] c);
		int i;
		for (i = 0; i < 3000 && cmd_ready_o !== 1'b1; i++) @(posedge clk_i);
		if (i == 3000) begin
			mismatches++;
			$display("wrong value cmd_ready expected 1 seen %b", cmd_ready_o);
		end
		pulse(c);
	endtask
	task await(input logic k);
		int i;
		for (i = 0; i < 4000 && (k ? line_condition_field_o !== `TWIMS_BS_IDLE
			: (write_done_o | read_done_o | arb_lost_o) !== 1'b1); i++) @(posedge clk_i);
		if (i == 4000) begin
			mismatches++;
			$display("wrong value wait_cycles expected below 4000 seen %0d", i);
		end
	endtask
	task conclude();
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Whole run is near 7000 cycles; the 40000-cycle limit cuts a hang short.
	initial begin
		#400000;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		resetn_i <= 1;
		enable_i <= 1;
		note(0, `TWIMS_BS_UNKNOWN);
		pulse(5'h10);
		note(0, `TWIMS_BS_UNKNOWN);
		ext_sda <= 1;
		repeat (6) @(posedge clk_i);
		ext_sda <= 0;
		repeat (6) @(posedge clk_i);
		note(0, `TWIMS_BS_IDLE);
		ext_sda <= 1;
		repeat (6) @(posedge clk_i);
		note(0, `TWIMS_BS_BUSY);
		pulse(5'h10);
		note(0, `TWIMS_BS_BUSY);
		ext_sda <= 0;
		repeat (6) @(posedge clk_i);
		note(0, `TWIMS_BS_IDLE);
		enable_i <= 0;
		repeat (3) @(posedge clk_i);
		note(0, `TWIMS_BS_UNKNOWN);
		enable_i <= 1;
		repeat (3) @(posedge clk_i);
		line_condition_wr_i <= 1;
		@(posedge clk_i) line_condition_wr_i <= 0;
		note(0, `TWIMS_BS_UNKNOWN);
		wdata <= 2'h1;
		line_condition_wr_i <= 1;
		@(posedge clk_i) line_condition_wr_i <= 0;
		note(0, `TWIMS_BS_IDLE);
		$display("bus monitor test done");
		// Modes: acked write, nacked write with stretching, read, lost arbitration.
		for (m = 0; m < 4; m++) begin
			mode <= m[1:0];
			stretch <= m[0];
			peer_data <= rnd();
			tx_data_i <= m == 3 ? 8'hff : rnd();
			div <= rnd() & 8'h0f;
			cmd_read_i <= m == 2;
			cmd(5'h10);
			repeat (2) @(posedge clk_i);
			note(0, `TWIMS_BS_OWNER);
			cmd(5'h04);
			await(0);
			if (m < 2) note(2, {5'h04, m[0], 2'h1});
			if (m == 2) note(3, 8'h02);
			if (m == 2) note(1, peer_data);
			if (m == 3) note(3, 8'h05);
			if (m == 3) note(0, `TWIMS_BS_BUSY);
			pulse(5'h03);
			note(3, 8'h00);
			if (m < 3) cmd(5'h08);
			mode <= 2'h1;
			ext_sda <= m == 3;
			repeat (6) @(posedge clk_i);
			ext_sda <= 0;
			await(1);
			note(0, `TWIMS_BS_IDLE);
			$display("transfer test %0d done", m);
		end
		enable_i <= 0;
		timeout_sel_i <= `TWIMS_TIMEOUT_50US;
		repeat (3) @(posedge clk_i);
		enable_i <= 1;
		note(0, `TWIMS_BS_UNKNOWN);
		repeat (`TWIMS_TO_50_CYC + 200) @(posedge clk_i);
		note(0, `TWIMS_BS_IDLE);
		$display("timeout test done");
		conclude();
	end
endmodule // twi_master_bus_state_clocking_test
`default_nettype wire
